// ---- fde_pkg.sv ----
/*
  Shared constants for the fault-detect enable and clear command block.
  Assumes a 200 MHz system clock and a host-driven serial command link.
*/
package fde_pkg;
  // ***********************************************************
  // Opcodes and command lengths
  // ***********************************************************
  localparam logic [7:0] FDE_OP_SETUP     = 8'h00_D0;
  localparam logic [7:0] FDE_OP_CLEAR     = 8'h00_FF;
  localparam logic [7:0] FDE_OP_ERR_READ  = 8'h00_B8;
  localparam logic [7:0] FDE_OP_ERR_MASK  = 8'h00_FE;
  localparam logic [7:0] FDE_OP_STAT_READ = 8'h00_B0;
  localparam logic [7:0] FDE_OP_VER_READ  = 8'h00_B4;
  localparam logic [7:0] FDE_OP_READ_MASK = 8'h00_FC;
  localparam logic [7:0] FDE_OP_PINSEL    = 8'h00_C0;
  localparam logic [7:0] FDE_OP_XADDR     = 8'h00_C4;
  localparam logic [7:0] FDE_OP_XPLAY     = 8'h00_C8;
  localparam logic [1:0] FDE_LEN_ONE      = 2'd1;
  localparam logic [1:0] FDE_LEN_TWO      = 2'd2;
  localparam logic [1:0] FDE_LEN_THREE    = 2'd3;
  // ***********************************************************
  // Enable / error field positions and reset value
  // ***********************************************************
  localparam int         FDE_B_BADCMD     = 0;
  localparam int         FDE_B_SPK_OPEN   = 1;
  localparam int         FDE_B_OVERTEMP   = 2;
  localparam int         FDE_B_SPK_SHORT  = 3;
  localparam int         FDE_B_FLASH      = 4;
  localparam int         FDE_B_WATCHDOG   = 5;
  localparam int         FDE_B_RECOVERY   = 6;
  localparam int         FDE_B_CLKSTOP    = 7;
  localparam logic [7:0] FDE_ENABLE_RST   = 8'h00_00;
  localparam logic [7:0] FDE_VERSION      = 8'h00_01; // Arbitrary value
  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int         FDE_WDT_W        = 16;
  localparam int         FDE_REC_W        = 16;
  localparam int         FDE_CLK_MHZ      = 200;
  localparam int         FDE_STOP_NS      = 1000;
  localparam int         FDE_STOP_CYC     = FDE_STOP_NS * FDE_CLK_MHZ / 1000;
endpackage

// ---- fde_sync.sv ----
/*
  Two-flop synchroniser for one level input.
  Assumes the input is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module fde_sync (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  // ***********************************************************
  // Sampling stages
  // ***********************************************************
  // Second stage alone reads the first
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ---- fde_core.sv ----
/*
  Serial command interpreter for fault-detect enables and error clear.
  Assumes a host drives a serial clock, data and chip select; analog
  fault sources arrive as level inputs; the resonator clock is a pin.
*/
`timescale 1ns/1ps
module fde_core
  import fde_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic ser_clk,
  input  wire logic ser_din,
  input  wire logic ser_csb,
  output logic      ser_dout,
  input  wire logic double_mode,
  input  wire logic wdt_kick,
  input  wire logic [4:0] fault_in,
  input  wire logic osc_clk,
  output logic      command_accept_ready,
  output logic      status_pin_one,
  output logic      status_pin_two,
  output logic [7:0] fault_detect_enable,
  output logic [7:0] error_bits
);
  // ***********************************************************
  // Pin synchronisers
  // ***********************************************************
  logic sck_s, din_s, csb_s, osc_s;
  fde_sync u_sck (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(ser_clk), .q(sck_s));
  fde_sync u_din (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(ser_din), .q(din_s));
  fde_sync u_csb (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(ser_csb), .q(csb_s));
  fde_sync u_osc (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(osc_clk), .q(osc_s));
  // Fault levels come from the analog side, two flops each
  logic [4:0] fault_s;
  for (genvar g = 0; g < 5; g++) begin : g_fault
    fde_sync u_flt (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(fault_in[g]), .q(fault_s[g]));
  end

  typedef enum logic [1:0] {FDE_OPC, FDE_ARG, FDE_RD} fde_state_e;

  logic       sck_d_r, osc_d_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] sh_r, tx_r, op_r;
  logic [1:0] byte_cnt_r;
  logic       half_r;
  fde_state_e st_r;
  logic [FDE_WDT_W-1:0] wdt_r;
  logic [FDE_REC_W-1:0] rec_r;
  logic       wdt_once_r, rec_run_r;
  logic [15:0] stop_cnt_r;

  // ***********************************************************
  // Decode
  // ***********************************************************
  wire        sck_rise  = sck_s & ~sck_d_r;
  wire        sck_fall  = ~sck_s & sck_d_r;
  wire        byte_done = sck_rise & ~csb_s & (bit_cnt_r == 3'd7);
  wire [7:0]  rx_byte   = {sh_r[6:0], din_s};
  // Two-times mode: second copy of each byte is the one acted on
  wire        acc_byte  = byte_done & (~double_mode | half_r);
  wire        is_clear  = (rx_byte == FDE_OP_CLEAR);
  wire        is_read   = ((rx_byte & FDE_OP_READ_MASK) == FDE_OP_STAT_READ)
                        | ((rx_byte & FDE_OP_READ_MASK) == FDE_OP_VER_READ)
                        | ((rx_byte & FDE_OP_ERR_MASK) == FDE_OP_ERR_READ);
  wire        is_three  = (rx_byte == FDE_OP_XADDR) | (rx_byte == FDE_OP_XPLAY);
  wire [1:0]  op_len    = is_clear ? FDE_LEN_ONE :
                          is_three ? FDE_LEN_THREE : FDE_LEN_TWO;
  wire        setup_wr  = acc_byte & (st_r == FDE_ARG) & (op_r == FDE_OP_SETUP);
  // Watchdog dropped when recovery also requested
  wire [7:0]  en_fix    = (rx_byte[FDE_B_WATCHDOG] & rx_byte[FDE_B_RECOVERY]) ?
                          (rx_byte & ~(8'h00_01 << FDE_B_WATCHDOG)) : rx_byte;
  wire        clear_cmd = acc_byte & (st_r == FDE_OPC) & is_clear;
  wire        wdt_ovf   = fault_detect_enable[FDE_B_WATCHDOG] & (&wdt_r);
  wire        rec_ovf   = rec_run_r & (&rec_r);
  wire        clk_stop  = stop_cnt_r >= 16'(FDE_STOP_CYC);
  // Raw fault conditions, each gated by its own enable
  wire [7:0]  raw_err   = {clk_stop, 1'b0, 1'b0, fault_s} & fault_detect_enable;
  wire [7:0]  set_err   = raw_err
                        | ({7'd0, wdt_ovf & ~wdt_once_r} << FDE_B_WATCHDOG)
                        | ({7'd0, (wdt_ovf & wdt_once_r) | rec_ovf} << FDE_B_RECOVERY);
  // Selected by the opcode being taken, not the previous one
  wire [7:0]  rd_data   = (rx_byte[2] ? FDE_VERSION :
                           ((rx_byte & FDE_OP_ERR_MASK) == FDE_OP_ERR_READ) ? error_bits :
                           {7'd0, command_accept_ready});
  wire        any_err   = |error_bits;

  assign command_accept_ready = (st_r == FDE_OPC) & csb_s;
  assign status_pin_one       = command_accept_ready;
  assign status_pin_two       = any_err;

  // ***********************************************************
  // Serial shifter and byte framing
  // ***********************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sck_d_r   <= 1'b0;
      bit_cnt_r <= 3'd0;
      sh_r      <= 8'h00_00;
      half_r    <= 1'b0;
    end else if (clk_en) begin
      sck_d_r <= sck_s;
      if (csb_s) begin
        bit_cnt_r <= 3'd0;
        half_r    <= 1'b0;
      end else if (sck_rise) begin
        bit_cnt_r <= bit_cnt_r + 3'd1;
        sh_r      <= rx_byte;
        if (bit_cnt_r == 3'd7)
          half_r <= double_mode & ~half_r;
      end
    end
  end

  // ***********************************************************
  // Command state machine
  // ***********************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r       <= FDE_OPC;
      op_r       <= 8'h00_00;
      byte_cnt_r <= 2'd0;
    end else if (clk_en) begin
      if (csb_s) begin
        st_r <= FDE_OPC;
      end else if (acc_byte) begin
        case (st_r)
          FDE_OPC: begin
            op_r       <= rx_byte;
            byte_cnt_r <= op_len - 2'd1;
            if (is_read)
              st_r <= FDE_RD;
            else if (op_len != FDE_LEN_ONE)
              st_r <= FDE_ARG;
          end
          FDE_ARG: begin
            byte_cnt_r <= byte_cnt_r - 2'd1;
            if (byte_cnt_r == 2'd1)
              st_r <= FDE_OPC;
          end
          FDE_RD:  st_r <= FDE_OPC;
          default: st_r <= FDE_OPC;
        endcase
      end
    end
  end

  // ***********************************************************
  // Enable register and read shifter
  // ***********************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fault_detect_enable <= FDE_ENABLE_RST;
      tx_r                <= 8'h00_00;
      ser_dout            <= 1'b0;
    end else if (clk_en) begin
      if (setup_wr)
        fault_detect_enable <= en_fix;
      if (acc_byte & (st_r == FDE_OPC) & is_read)
        tx_r <= rd_data;
      else if (sck_fall & (st_r == FDE_RD)) begin
        ser_dout <= tx_r[7];
        tx_r     <= {tx_r[6:0], tx_r[7]};
      end
    end
  end

  // ***********************************************************
  // Watchdog, recovery counter, clock-stop monitor
  // ***********************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wdt_r      <= '0;
      wdt_once_r <= 1'b0;
      rec_r      <= '0;
      rec_run_r  <= 1'b0;
      osc_d_r    <= 1'b0;
      stop_cnt_r <= 16'd0;
    end else if (clk_en) begin
      osc_d_r <= osc_s;
      if (osc_s != osc_d_r)
        stop_cnt_r <= 16'd0;
      else if (!clk_stop)
        stop_cnt_r <= stop_cnt_r + 16'd1;
      // Watchdog runs only while enabled
      if (!fault_detect_enable[FDE_B_WATCHDOG] | wdt_kick)
        wdt_r <= '0;
      else
        wdt_r <= wdt_r + 1'b1;
      if (wdt_ovf)
        wdt_once_r <= 1'b1;
      // Recovery counter starts on any latched error
      if (fault_detect_enable[FDE_B_RECOVERY] & (any_err | rec_run_r)) begin
        rec_run_r <= ~rec_ovf;
        rec_r     <= rec_r + 1'b1;
      end else begin
        rec_run_r <= 1'b0;
        rec_r     <= '0;
      end
    end
  end

  // ***********************************************************
  // Latched error bits
  // ***********************************************************
  // Set wins over clear so a standing fault stays visible
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      error_bits <= 8'h00_00;
    else if (clk_en) begin
      if (clear_cmd)
        error_bits <= set_err;
      else
        error_bits <= error_bits | set_err;
    end
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  // Setup argument byte accepted
  sequence s_setup_byte;
    setup_wr && clk_en;
  endsequence

  // Opcode byte accepted while idle
  sequence s_opcode_taken;
    clk_en && acc_byte && (st_r == FDE_OPC);
  endsequence

  // First copy of a byte in two-times mode
  sequence s_first_copy;
    clk_en && byte_done && double_mode && !half_r;
  endsequence

  // Enable register
  chk_reset_zero: assert property (
    @(posedge clk_sys) $fell(sys_rst) |-> fault_detect_enable == 8'h00_00)
    else $error("enables not zero after reset");
  chk_setup_store: assert property (
    @(posedge clk_sys) disable iff (sys_rst) s_setup_byte |=>
    {fault_detect_enable[7:6], fault_detect_enable[4:0]} == $past({rx_byte[7:6], rx_byte[4:0]}))
    else $error("setup byte not stored");
  chk_wdt_rec_excl: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !(fault_detect_enable[FDE_B_WATCHDOG] && fault_detect_enable[FDE_B_RECOVERY]))
    else $error("watchdog and recovery both set");

  // Watchdog and recovery counter
  chk_wdt_idle: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en && !fault_detect_enable[FDE_B_WATCHDOG] |=> wdt_r == '0)
    else $error("watchdog runs while disabled");
  chk_wdt_first: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en && wdt_ovf && !wdt_once_r |=> error_bits[FDE_B_WATCHDOG])
    else $error("watchdog bit not set");
  chk_rec_start: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en && fault_detect_enable[FDE_B_RECOVERY] && any_err && !rec_ovf |=> rec_run_r)
    else $error("recovery counter idle");

  // Error latch
  chk_clkstop_gate: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !fault_detect_enable[FDE_B_CLKSTOP] && !error_bits[FDE_B_CLKSTOP] |=>
    !error_bits[FDE_B_CLKSTOP])
    else $error("clock stop reported while off");
  chk_gate_bits: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en && clear_cmd && fault_detect_enable[4:0] == 5'd0 |=> error_bits[4:0] == 5'd0)
    else $error("disabled detector latched");
  chk_clear_sticky: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en && clear_cmd && raw_err[0] |=> error_bits[0])
    else $error("standing fault cleared");
  chk_clear_act: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en && clear_cmd && set_err == 8'h00_00 |=> error_bits == 8'h00_00)
    else $error("clear had no effect");

  // Command framing
  chk_one_byte: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    s_opcode_taken ##0 is_clear |=> st_r == FDE_OPC)
    else $error("clear not a one-byte command");
  chk_three_len: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    s_opcode_taken ##0 is_three |=> st_r == FDE_ARG && byte_cnt_r == 2'd2)
    else $error("three-byte command length wrong");
  chk_read_entry: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    s_opcode_taken ##0 is_read |=> st_r == FDE_RD)
    else $error("read command gave no data byte");
  chk_double_skip: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    s_first_copy |=> $stable(st_r) && $stable(fault_detect_enable))
    else $error("first copy acted on in two-times mode");
endmodule

// ---- fde_host.sv ----
/*
  Host model for the serial command link of the fault-detect block.
  Assumes it is clocked by clk_sys; link clock idles high between frames.
*/
`timescale 1ns/1ps
module fde_host (
  input  wire logic clk_sys,
  output logic      ser_clk,
  output logic      ser_din,
  output logic      ser_csb,
  input  wire logic ser_dout
);
  // ***********************************************************
  // Link driver
  // ***********************************************************
  logic [7:0] rd_byte;

  // Idle levels at time zero
  initial begin
    ser_clk = 1'b1;
    ser_din = 1'b1;
    ser_csb = 1'b1;
    rd_byte = 8'h00_00;
  end

  // One bit of 125 ns: fall with data, rise after 12 cycles, capture
  task automatic bit_out(input logic b);
    @(posedge clk_sys);
    ser_clk <= 1'b0;
    ser_din <= b;
    repeat (12) @(posedge clk_sys);
    ser_clk <= 1'b1;
    rd_byte <= {rd_byte[6:0], ser_dout};
    repeat (12) @(posedge clk_sys);
  endtask

  // Whole frame, MSB first; a short count leaves a partial byte
  task automatic frame(input logic [7:0] q[$], input int bits);
    repeat (4) @(posedge clk_sys);
    ser_csb <= 1'b0;
    for (int i = 0; i < bits; i++) begin
      bit_out(q[i / 8][7 - i % 8]);
    end
    @(posedge clk_sys);
    ser_csb <= 1'b1;
    ser_din <= ~ser_din;
  endtask
endmodule

// ---- fde_core_bench.sv ----
/*
  Self-checking bench for the fault-detect enable and clear block.
  Assumes the host model drives the link and notes are checked in order.
*/
`timescale 1ns/1ps
module fde_core_bench;
  import fde_pkg::*;
  typedef struct {logic [1:0] kind; logic [7:0] val;} fde_note_s;
  // ***********************************************************
  // Signals and instances
  // ***********************************************************
  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       clk_en = 1'b1;
  logic       double_mode = 1'b0;
  logic       wdt_kick = 1'b1;
  logic [4:0] fault_in = 5'h0_0;
  logic       osc_run = 1'b1;
  logic [3:0] osc_cnt = 4'h0;
  logic       osc_clk;
  logic       ser_clk, ser_din, ser_csb, ser_dout;
  logic       ready, pin_one, pin_two;
  logic [7:0] enables, err_bits, seen;
  logic [4:0] r;
  logic       look = 1'b0;
  int         seed = 82;
  int         errors = 0;
  int         checks_done = 0;
  fde_note_s  notes[$];
  fde_note_s  note;
  string      names[4] = '{"enables", "error_bits", "read_byte", "status_pin_two"};

  always #2.5 clk_sys = ~clk_sys;

  // Resonator stand-in, stopped by the bench on demand
  always @(posedge clk_sys) osc_cnt <= osc_cnt + 4'h1;
  assign osc_clk = osc_run & osc_cnt[3];

  fde_core fde_core_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .ser_clk(ser_clk), .ser_din(ser_din), .ser_csb(ser_csb), .ser_dout(ser_dout),
    .double_mode(double_mode), .wdt_kick(wdt_kick), .fault_in(fault_in),
    .osc_clk(osc_clk), .command_accept_ready(ready), .status_pin_one(pin_one),
    .status_pin_two(pin_two), .fault_detect_enable(enables), .error_bits(err_bits));

  fde_host fde_host_i (.clk_sys(clk_sys), .ser_clk(ser_clk), .ser_din(ser_din),
    .ser_csb(ser_csb), .ser_dout(ser_dout));

  // ***********************************************************
  // Notes, watcher and verdict
  // ***********************************************************
  task automatic chk(input logic [1:0] k, input logic [7:0] v);
    notes.push_back('{k, v});
    look <= 1'b1;
    @(posedge clk_sys);
    look <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic setup(input logic [7:0] v);
    fde_host_i.frame({FDE_OP_SETUP, v}, 16);
  endtask

  task automatic clear_errs;
    fde_host_i.frame({FDE_OP_CLEAR}, 8);
    repeat (4) @(posedge clk_sys);
  endtask

  // Oldest note against the output it names
  always @(posedge clk_sys) begin
    if (look) begin
      note = notes.pop_front();
      case (note.kind)
        2'd0: seen = enables;
        2'd1: seen = err_bits;
        2'd2: seen = fde_host_i.rd_byte;
        default: seen = {7'h00, pin_two};
      endcase
      checks_done++;
      if (seen !== note.val) begin
        errors++;
        $display("CHECK FAILED %s expected %h seen %h", names[note.kind], note.val, seen);
      end
    end
  end

  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard, about 90k clock cycles; the tests need about 76k
  initial begin
    #450_000;
    errors++;
    give_verdict();
  end

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(2'd0, FDE_ENABLE_RST);
    chk(2'd1, 8'h00_00);
    for (int i = 0; i < 8; i++) begin
      setup(8'h01 << i);
      chk(2'd0, 8'h01 << i);
    end
    setup(8'h00_60);
    chk(2'd0, 8'h00_40);
    setup(8'h00_FF);
    chk(2'd0, 8'h00_DF);
    fde_host_i.frame({FDE_OP_SETUP, 8'h00_00}, 12);
    chk(2'd0, 8'h00_DF);
    double_mode <= 1'b1;
    fde_host_i.frame({FDE_OP_SETUP, FDE_OP_SETUP, 8'h00_5D, 8'h00_5D}, 32);
    double_mode <= 1'b0;
    chk(2'd0, 8'h00_5D);
    fde_host_i.frame({FDE_OP_XADDR, FDE_OP_SETUP, FDE_OP_SETUP, 8'h00_12}, 32);
    chk(2'd0, 8'h00_5D);
    fde_host_i.frame({FDE_OP_VER_READ, 8'h00_00}, 16);
    chk(2'd2, FDE_VERSION);
    clear_errs();
    r = 5'($random(seed)) | 5'h01;
    fault_in <= r;
    repeat (8) @(posedge clk_sys);
    chk(2'd1, {3'h0, r & 5'h1D});
    chk(2'd3, 8'h00_01);
    fde_host_i.frame({FDE_OP_ERR_READ, 8'h00_00}, 16);
    if (pin_two && fde_host_i.rd_byte == 8'h00_00)
      fde_host_i.frame({FDE_OP_ERR_READ, 8'h00_00}, 16);
    chk(2'd2, {3'h0, r & 5'h1D});
    fault_in <= 5'h01;
    clear_errs();
    chk(2'd1, 8'h00_01);
    fault_in <= 5'h00;
    clear_errs();
    chk(2'd1, 8'h00_00);
    setup(8'h00_00);
    osc_run <= 1'b0;
    repeat (300) @(posedge clk_sys);
    chk(2'd1, 8'h00_00);
    osc_run <= 1'b1;
    setup(8'h00_80);
    osc_run <= 1'b0;
    repeat (300) @(posedge clk_sys);
    chk(2'd1, 8'h00_80);
    osc_run <= 1'b1;
    repeat (20) @(posedge clk_sys);
    clear_errs();
    chk(2'd1, 8'h00_00);
    setup(8'h00_20);
    wdt_kick <= 1'b0;
    for (int w = 0; w < 70000 && err_bits[5] !== 1'b1; w++) @(posedge clk_sys);
    chk(2'd1, 8'h00_20);
    give_verdict();
  end
endmodule
